/* File: sim/ahp_host_model.sv */
// host microprocessor side: strobes, bus data and the conversion clock
module ahp_host_model (
    input wire logic clk,                // system clock
    input wire logic [7:0] data_out,     // device bus output
    input wire logic data_oe,            // device bus drive enable
    output logic cs_n,                   // chip select
    output logic wr_n,                   // write strobe
    output logic rd_n,                   // read strobe
    output logic high_byte_select,       // nibble lane select
    output logic [7:0] data_in,          // bus data to device
    output logic conv_clk_in             // external conversion clock
);
    timeunit 1ns;
    timeprecision 100ps;

    int unsigned div_cnt;

    // idle levels at time zero
    initial
    begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        high_byte_select = 1'b0;
        data_in = 8'h00;
        conv_clk_in = 1'b0;
        div_cnt = 0;
    end

    // free running clock, six system cycles a period, never paused
    always @(posedge clk)
    begin
        #2;
        if (div_cnt == 2)
        begin
            div_cnt = 0;
            conv_clk_in = ~conv_clk_in;
        end
        else
        begin
            div_cnt = div_cnt + 1;
        end
    end

    // one write pulse; data held through the edge that sees the rise
    task write_byte(input logic [7:0] b, input logic sel_n);
        @(posedge clk);
        #2;
        cs_n = sel_n;
        wr_n = 1'b0;
        data_in = b;
        @(posedge clk);
        #2;
        wr_n = 1'b1;
        @(posedge clk);
        #2;
        cs_n = 1'b1;
        data_in = ~b; // released bus shows no stale byte
    endtask : write_byte

    // one read; lane sampled two edges after the strobe falls
    task read_byte(input logic hb, input logic sel_n,
                   output logic [7:0] v, output logic oe);
        @(posedge clk);
        #2;
        cs_n = sel_n;
        rd_n = 1'b0;
        high_byte_select = hb;
        @(posedge clk);
        @(posedge clk);
        #2;
        v = data_out;
        oe = data_oe;
        rd_n = 1'b1;
        cs_n = 1'b1;
    endtask : read_byte
endmodule : ahp_host_model

/* File: sim/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int DIV = 2; // short internal tick to keep the run brief

    logic clk, rst_n, ce, power_off_n;
    logic cs_n, wr_n, rd_n, high_byte_select, conv_clk_in;
    logic [7:0] data_in, data_out, rv;
    logic [11:0] sample_data;
    logic data_oe, done_n, full_power_down, standby_power_down;
    logic int_clk_mode, acquire_timing_sel, bipolar_sel, range_sel;
    logic [2:0] channel_sel;
    logic tracking, converting, roe;
    int n_fail, samples_checked, cycles;

    ahp_host_port #(.INT_CLK_DIV(DIV)) i_dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .cs_n(cs_n), .wr_n(wr_n),
        .rd_n(rd_n), .high_byte_select(high_byte_select),
        .power_off_n(power_off_n), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe),
        .conv_clk_in(conv_clk_in), .sample_data(sample_data),
        .done_n(done_n), .full_power_down(full_power_down),
        .standby_power_down(standby_power_down),
        .int_clk_mode(int_clk_mode),
        .acquire_timing_sel(acquire_timing_sel),
        .bipolar_sel(bipolar_sel), .range_sel(range_sel),
        .channel_sel(channel_sel), .tracking(tracking),
        .converting(converting));

    ahp_host_model i_host (
        .clk(clk), .data_out(data_out), .data_oe(data_oe), .cs_n(cs_n),
        .wr_n(wr_n), .rd_n(rd_n), .high_byte_select(high_byte_select),
        .data_in(data_in), .conv_clk_in(conv_clk_in));

    // system clock, 40 ns period
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task test_done;
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    task chk(input string name, input logic [11:0] exp,
             input logic [11:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task chk_rng(input string name, input int lo, input int hi,
                 input int got);
        samples_checked++;
        if (got < lo || got > hi)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi,
                     got);
        end
    endtask : chk_rng

    // wait for done, timing conversion and, unless ext, sampling; per is clk cycles per tick
    task run_conv(input int per, input bit ext);
        int nt, nc, n;
        nt = 0;
        nc = 0;
        n = 0;
        while (done_n !== 1'b0 && n < 400)
        begin
            @(posedge clk);
            #3;
            n++;
            if (tracking === 1'b1)
                nt++;
            if (converting === 1'b1)
                nc++;
        end
        chk("done_n", 12'h000, 12'(done_n));
        if (!ext)
            chk_rng("sample len", 5 * per, 7 * per, nt);
        chk_rng("convert len", 11 * per, 13 * per, nc);
    endtask : run_conv

    // cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_fail++;
            $display("[FAIL] timeout expected finish seen hang");
            test_done;
        end
    end

    // main sequence
    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        power_off_n = 1'b1;
        sample_data = 12'h09a5;
        n_fail = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (2) @(posedge clk);
        #2;
        rst_n = 1'b1;
        #1;
        chk("done_n", 12'h001, 12'(done_n));
        chk("data_oe", 12'h000, 12'(data_oe));
        chk("tracking", 12'h000, 12'(tracking));
        chk("int_clk_mode", 12'h000, 12'(int_clk_mode));
        // internal sampling, external clock, bipolar, wide range, channel 3
        i_host.write_byte(8'h1b, 1'b0);
        chk("channel_sel", 12'h003, 12'(channel_sel));
        chk("range_sel", 12'h001, 12'(range_sel));
        chk("bipolar_sel", 12'h001, 12'(bipolar_sel));
        chk("acq_sel", 12'h000, 12'(acquire_timing_sel));
        run_conv(6, 1'b0);
        i_host.read_byte(1'b0, 1'b0, rv, roe);
        chk("low lane", 12'h0a5, 12'(rv));
        chk("oe reading", 12'h001, 12'(roe));
        chk("done_n read", 12'h001, 12'(done_n));
        #1;
        chk("oe released", 12'h000, 12'(data_oe));
        i_host.read_byte(1'b1, 1'b0, rv, roe);
        chk("high lane bip", 12'h0f9, 12'(rv));
        // internal clock, unipolar high lane
        i_host.write_byte(8'h40, 1'b0);
        chk("int_clk_mode", 12'h001, 12'(int_clk_mode));
        run_conv(DIV, 1'b0);
        i_host.read_byte(1'b1, 1'b0, rv, roe);
        chk("high lane uni", 12'h009, 12'(rv));
        // write-timed sampling waits for the second write
        i_host.write_byte(8'h20, 1'b0);
        chk("acq_sel", 12'h001, 12'(acquire_timing_sel));
        repeat (100) @(posedge clk);
        #2;
        chk("ext tracking", 12'h001, 12'(tracking));
        chk("ext converting", 12'h000, 12'(converting));
        // a write while the clock enable is low must be lost entirely
        ce = 1'b0;
        i_host.write_byte(8'h00, 1'b0);
        ce = 1'b1;
        chk("frozen converting", 12'h000, 12'(converting));
        chk("frozen tracking", 12'h001, 12'(tracking));
        sample_data = 12'h0370;
        i_host.write_byte(8'h00, 1'b0);
        run_conv(6, 1'b1);
        i_host.read_byte(1'b0, 1'b0, rv, roe);
        chk("low lane ext", 12'h070, 12'(rv));
        // deselected strobes are ignored, bus left released
        i_host.write_byte(8'h00, 1'b1);
        i_host.read_byte(1'b0, 1'b1, rv, roe);
        chk("oe deselected", 12'h000, 12'(roe));
        chk("idle tracking", 12'h000, 12'(tracking));
        // shutdown pin blocks starts and forces power-down
        power_off_n = 1'b0;
        @(posedge clk);
        #2;
        chk("pin power-down", 12'h001, 12'(full_power_down));
        i_host.write_byte(8'h00, 1'b0);
        repeat (3) @(posedge clk);
        #2;
        chk("shut tracking", 12'h000, 12'(tracking));
        power_off_n = 1'b1;
        // programmed standby is not a full power-down
        i_host.write_byte(8'h80, 1'b0);
        chk("standby", 12'h001, 12'(standby_power_down));
        chk("standby full", 12'h000, 12'(full_power_down));
        i_host.write_byte(8'hc0, 1'b0);
        chk("prog power-down", 12'h001, 12'(full_power_down));
        chk("prog standby", 12'h000, 12'(standby_power_down));
        test_done;
    end
endmodule : tb_top

/* File: src/ahp_conv_seq.sv */
module ahp_conv_seq #(
    parameter int ACQ_TICKS = ahp_pkg::ACQ_TICKS,
    parameter int CONV_TICKS = ahp_pkg::CONV_TICKS
)(
    input wire logic clk,    // system clock
    input wire logic rst_n,  // sync reset, active low
    input wire logic ce,     // clock enable
    ahp_seq_if.seq sq        // sequencer control
);
    localparam logic [ahp_pkg::CNT_W-1:0] ACQ_LAST =
        ahp_pkg::CNT_W'(ACQ_TICKS - 1);
    localparam logic [ahp_pkg::CNT_W-1:0] CONV_LAST =
        ahp_pkg::CNT_W'(CONV_TICKS - 1);

    ahp_pkg::ahp_state_e state_reg;
    ahp_pkg::ahp_state_e state_next;
    logic [ahp_pkg::CNT_W-1:0] cnt_reg;
    logic [ahp_pkg::CNT_W-1:0] cnt_next;
    logic done_reg;
    logic done_next;

    assign sq.state = state_reg;
    assign sq.done = done_reg;

    // next state; stop beats a restart, a restart aborts any phase
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        done_next = 1'b0;
        if (sq.stop)
        begin
            state_next = ahp_pkg::AHP_IDLE;
            cnt_next = '0;
        end
        else if (sq.start)
        begin
            state_next = sq.ext_acq ? ahp_pkg::AHP_EXT_ACQ
                                    : ahp_pkg::AHP_ACQ;
            cnt_next = '0;
        end
        else if (sq.conv_go && state_reg == ahp_pkg::AHP_EXT_ACQ)
        begin
            state_next = ahp_pkg::AHP_CONV;
            cnt_next = '0;
        end
        else
        begin
            case (state_reg)
                ahp_pkg::AHP_IDLE:
                begin
                    cnt_next = '0;
                end
                ahp_pkg::AHP_ACQ:
                begin
                    if (sq.tick && cnt_reg == ACQ_LAST)
                    begin
                        state_next = ahp_pkg::AHP_CONV;
                        cnt_next = '0;
                    end
                    else if (sq.tick)
                    begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
                ahp_pkg::AHP_EXT_ACQ:
                begin
                    cnt_next = '0;
                end
                ahp_pkg::AHP_CONV:
                begin
                    if (sq.tick && cnt_reg == CONV_LAST)
                    begin
                        state_next = ahp_pkg::AHP_IDLE;
                        cnt_next = '0;
                        done_next = 1'b1;
                    end
                    else if (sq.tick)
                    begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
                default:
                begin
                    state_next = ahp_pkg::AHP_IDLE;
                    cnt_next = '0;
                end
            endcase
        end
    end

    // state registers, frozen while ce is low
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= ahp_pkg::AHP_IDLE;
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end
        else if (ce)
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            done_reg <= done_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    // sampling ends exactly on the sixth tick
    AST_ACQ_LEN: assert property (
        state_reg == ahp_pkg::AHP_ACQ && sq.tick && cnt_reg == ACQ_LAST
        && !sq.stop && !sq.start |=> state_reg == ahp_pkg::AHP_CONV)
        else $error("acquisition did not end on sixth tick");
    AST_ACQ_HOLD: assert property (
        state_reg == ahp_pkg::AHP_ACQ && !sq.tick && !sq.stop
        && !sq.start |=> state_reg == ahp_pkg::AHP_ACQ && $stable(cnt_reg))
        else $error("acquisition moved without a tick");
    AST_CONV_LEN: assert property (
        state_reg == ahp_pkg::AHP_CONV && sq.tick && cnt_reg == CONV_LAST
        && !sq.stop && !sq.start |=> done_reg
        && state_reg == ahp_pkg::AHP_IDLE)
        else $error("conversion did not end on twelfth tick");
    AST_STOP_IDLE: assert property (
        sq.stop |=> state_reg == ahp_pkg::AHP_IDLE && !done_reg)
        else $error("shutdown left sequencer running");
    AST_EXT_WAIT: assert property (
        state_reg == ahp_pkg::AHP_EXT_ACQ && !sq.conv_go && !sq.start
        && !sq.stop |=> state_reg == ahp_pkg::AHP_EXT_ACQ)
        else $error("external acquisition ended without a write");

endmodule : ahp_conv_seq

/* File: src/ahp_host_port.sv */
// Function
// - internal timing: write rise latches config, then samples and converts.
// - external timing: first write rise samples, next one starts conversion.
// - select low and read falling edge enable driving result onto bus.
// - byte select low gives low 8 result bits, high gives top 4.
// - high byte puts result bits 8..11 on lines 0..3.
// - shutdown pin low forces full power-down whatever the programmed mode.
// - done output goes low when a conversion finishes and result is ready.
// - config bit 5 picks 6-tick internal sampling or write-timed sampling.
// - select high ignores both strobes and releases the data bus.
// - each conversion takes 12 conversion clock ticks.
// - high byte lines 4..7 are zero unipolar, sign copies bipolar.
module ahp_host_port #(
    parameter int ACQ_TICKS = ahp_pkg::ACQ_TICKS,
    parameter int CONV_TICKS = ahp_pkg::CONV_TICKS,
    parameter int INT_CLK_DIV = ahp_pkg::INT_CLK_DIV
)(
    input wire logic clk,                  // system clock, 25 MHz
    input wire logic rst_n,                // sync reset, active low
    input wire logic ce,                   // clock enable
    input wire logic cs_n,                 // chip select, active low
    input wire logic wr_n,                 // write strobe, active low
    input wire logic rd_n,                 // read strobe, active low
    input wire logic high_byte_select,     // high nibble select
    input wire logic power_off_n,          // shutdown, active low
    input wire logic [7:0] data_in,        // bus input side
    output logic [7:0] data_out,           // bus output side
    output logic data_oe,                  // bus drive enable
    input wire logic conv_clk_in,          // external conversion clock
    input wire logic [11:0] sample_data,   // converter core result
    output logic done_n,                   // conversion done, active low
    output logic full_power_down,          // full power-down active
    output logic standby_power_down,       // standby power-down active
    output logic int_clk_mode,             // internal conversion clock
    output logic acquire_timing_sel,       // write-timed sampling
    output logic bipolar_sel,              // bipolar coding
    output logic range_sel,                // full-scale range select
    output logic [2:0] channel_sel,        // input mux channel
    output logic tracking,                 // sampling phase active
    output logic converting                // conversion phase active
);
    localparam logic [ahp_pkg::DIV_W-1:0] DIV_LAST =
        ahp_pkg::DIV_W'(INT_CLK_DIV - 1);

    ahp_seq_if sq ();

    logic wr_prev_reg;
    logic rd_prev_reg;
    logic clkin_prev_reg;
    logic [7:0] cfg_reg;
    logic clk_int_reg;
    logic [ahp_pkg::DIV_W-1:0] div_reg;
    logic [ahp_pkg::DIV_W-1:0] div_next;
    logic [11:0] result_reg;
    logic done_n_reg;
    logic rd_en_reg;
    logic [7:0] dout_reg;
    logic [7:0] dout_next;

    wire logic selected = !cs_n;
    wire logic wr_rise = selected && !wr_prev_reg && wr_n;
    wire logic rd_fall = selected && rd_prev_reg && !rd_n;
    wire logic ext_wait = (sq.state == ahp_pkg::AHP_EXT_ACQ);
    wire logic [1:0] pd_mode =
        cfg_reg[ahp_pkg::CFG_PD_HI:ahp_pkg::CFG_PD_LO];
    wire logic [1:0] pd_in = data_in[ahp_pkg::CFG_PD_HI:ahp_pkg::CFG_PD_LO];
    wire logic div_wrap = (div_reg == DIV_LAST);
    wire logic ext_edge = conv_clk_in && !clkin_prev_reg;
    wire logic sign_fill =
        cfg_reg[ahp_pkg::CFG_BIP_BIT] && result_reg[11];

    // strobe decode to sequencer; a write while waiting ends sampling
    assign sq.start = wr_rise && power_off_n && !ext_wait;
    assign sq.conv_go = wr_rise && power_off_n && ext_wait;
    assign sq.ext_acq = data_in[ahp_pkg::CFG_ACQ_BIT];
    assign sq.stop = !power_off_n;
    // external clock relies on the host keeping it running
    assign sq.tick = clk_int_reg ? div_wrap : ext_edge;
    assign div_next = div_wrap ? '0 : div_reg + 5'h01;

    // byte lane mux, sign or zero fill above the high nibble
    assign dout_next = high_byte_select
        ? {{4{sign_fill}}, result_reg[11:8]}
        : result_reg[7:0];

    ahp_conv_seq #(
        .ACQ_TICKS(ACQ_TICKS),
        .CONV_TICKS(CONV_TICKS)
    ) u_seq (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .sq(sq.seq)
    );

    // strobe and clock history for edge detection
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_prev_reg <= 1'b1;
            rd_prev_reg <= 1'b1;
            clkin_prev_reg <= 1'b0;
        end
        else if (ce)
        begin
            wr_prev_reg <= wr_n;
            rd_prev_reg <= rd_n;
            clkin_prev_reg <= conv_clk_in;
        end
    end

    // configuration byte; power-down codes keep the old clock mode
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cfg_reg <= ahp_pkg::CFG_RESET;
            clk_int_reg <= ahp_pkg::CLK_INT_RESET;
        end
        else if (ce && wr_rise)
        begin
            cfg_reg <= data_in;
            if (!pd_in[1])
            begin
                clk_int_reg <= (pd_in == ahp_pkg::PD_NORM_INT);
            end
        end
    end

    // internal conversion clock divider, free running in that mode
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            div_reg <= '0;
        end
        else if (ce)
        begin
            div_reg <= clk_int_reg ? div_next : '0;
        end
    end

    // result capture and done flag; a finish beats a read start
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            result_reg <= ahp_pkg::RESULT_RESET;
            done_n_reg <= 1'b1;
        end
        else if (ce)
        begin
            if (sq.done)
            begin
                result_reg <= sample_data;
                done_n_reg <= 1'b0;
            end
            else if (rd_fall)
            begin
                done_n_reg <= 1'b1;
            end
        end
    end

    // read enable armed by the falling edge, dropped on release
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rd_en_reg <= 1'b0;
            dout_reg <= 8'h00;
        end
        else if (ce)
        begin
            rd_en_reg <= rd_fall || (rd_en_reg && selected && !rd_n);
            dout_reg <= dout_next;
        end
    end

    // enable gated live so a select release frees the bus at once
    assign data_oe = rd_en_reg && selected && !rd_n;
    assign data_out = dout_reg;
    assign done_n = done_n_reg;
    assign full_power_down = !power_off_n || pd_mode == ahp_pkg::PD_FULL;
    assign standby_power_down = power_off_n
        && pd_mode == ahp_pkg::PD_STANDBY;
    assign int_clk_mode = clk_int_reg;
    assign acquire_timing_sel = cfg_reg[ahp_pkg::CFG_ACQ_BIT];
    assign bipolar_sel = cfg_reg[ahp_pkg::CFG_BIP_BIT];
    assign range_sel = cfg_reg[ahp_pkg::CFG_RNG_BIT];
    assign channel_sel = cfg_reg[ahp_pkg::CFG_CH_HI:0];
    assign tracking = (sq.state == ahp_pkg::AHP_ACQ) || ext_wait;
    assign converting = (sq.state == ahp_pkg::AHP_CONV);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    AST_WR_CAPTURE: assert property (
        wr_rise |=> cfg_reg == $past(data_in))
        else $error("config byte not captured on write");
    AST_INT_START: assert property (
        wr_rise && power_off_n && !ext_wait && !data_in[5]
        |=> sq.state == ahp_pkg::AHP_ACQ)
        else $error("internal write did not start sampling");
    AST_EXT_CONV: assert property (
        wr_rise && power_off_n && ext_wait
        |=> converting ##1 !tracking)
        else $error("second write did not start conversion");
    AST_READ_OE: assert property (
        rd_fall ##1 (selected && !rd_n) |-> data_oe)
        else $error("read edge did not enable bus");
    AST_CS_HIZ: assert property (
        cs_n |-> !data_oe)
        else $error("bus driven while deselected");
    AST_CS_NO_WRITE: assert property (
        cs_n |=> $stable(cfg_reg))
        else $error("write taken while deselected");
    AST_LOW_BYTE: assert property (
        !high_byte_select |=> data_out == $past(result_reg[7:0]))
        else $error("low byte lane wrong");
    AST_HIGH_BYTE: assert property (
        high_byte_select |=> data_out[3:0] == $past(result_reg[11:8])
        && data_out[7:4] == {4{$past(sign_fill)}})
        else $error("high byte lane wrong");
    AST_POWER_OFF_N: assert property (
        !power_off_n |-> full_power_down ##1 !converting)
        else $error("shutdown pin not honoured");
    AST_DONE_LOW: assert property (
        sq.done |=> !done_n && result_reg == $past(sample_data))
        else $error("done not raised on completion");
    AST_DONE_CLR: assert property (
        rd_fall && !sq.done && !done_n |=> done_n)
        else $error("done not cleared on read");

    COV_INT_CONV: cover property (sq.state == ahp_pkg::AHP_ACQ
        ##[1:1000] sq.done);
    COV_EXT_CONV: cover property (sq.conv_go ##[1:1000] sq.done);
    COV_HIGH_READ: cover property (data_oe && high_byte_select && !done_n);
    COV_ABORT: cover property (converting && sq.start);

endmodule : ahp_host_port

/* File: src/ahp_pkg.sv */
package ahp_pkg;

    // converter timing, in conversion clock ticks
    localparam int ACQ_TICKS = 6;
    localparam int CONV_TICKS = 12;
    localparam int CNT_W = 4;

    // system clock and internal conversion clock rates
    localparam int CLK_HZ = 25_000_000;
    localparam int INT_CLK_HZ = 1_560_000;
    // one internal tick per this many clk cycles, rounded down
    localparam int INT_CLK_DIV = CLK_HZ / INT_CLK_HZ;
    localparam int DIV_W = 5;

    // configuration byte field positions
    localparam int CFG_PD_HI = 7;
    localparam int CFG_PD_LO = 6;
    localparam int CFG_ACQ_BIT = 5;
    localparam int CFG_RNG_BIT = 4;
    localparam int CFG_BIP_BIT = 3;
    localparam int CFG_CH_HI = 2;

    // power/clock mode encodings of the two top bits
    localparam logic [1:0] PD_NORM_EXT = 2'h0;
    localparam logic [1:0] PD_NORM_INT = 2'h1;
    localparam logic [1:0] PD_STANDBY = 2'h2;
    localparam logic [1:0] PD_FULL = 2'h3;

    // values after reset
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic CLK_INT_RESET = 1'b0;

    typedef enum logic [3:0]
    {
        AHP_IDLE = 4'b0001,
        AHP_ACQ = 4'b0010,
        AHP_EXT_ACQ = 4'b0100,
        AHP_CONV = 4'b1000
    } ahp_state_e;

endpackage : ahp_pkg

/* File: src/ahp_seq_if.sv */
interface ahp_seq_if;
    logic start;
    logic ext_acq;
    logic conv_go;
    logic stop;
    logic tick;
    logic done;
    ahp_pkg::ahp_state_e state;

    modport ctrl
    (
        output start, ext_acq, conv_go, stop, tick,
        input done, state
    );
    modport seq
    (
        input start, ext_acq, conv_go, stop, tick,
        output done, state
    );
endinterface : ahp_seq_if
